// ---- rtl/sdcb_pkg.sv ----
// shared constants and carrier types for the sdram command and burst core
package sdcb_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int COL_W  = 8;
  localparam int BANK_W = 2;
  localparam int NBANK  = 4;
  localparam int DATA_W = 32;
  localparam int NBYTE  = 4;

  // ----------------------------------------------------------------
  // mode word layout and codes
  // ----------------------------------------------------------------
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int AP_BIT      = 10;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_3    = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RST = 11'h000;
  localparam logic [COL_W-1:0]  MASK_1   = 8'h00;
  localparam logic [COL_W-1:0]  MASK_2   = 8'h01;
  localparam logic [COL_W-1:0]  MASK_4   = 8'h03;
  localparam logic [COL_W-1:0]  MASK_8   = 8'h07;
  localparam logic [COL_W-1:0]  MASK_PG  = 8'hFF;

  // ----------------------------------------------------------------
  // command encodings {row, column, write strobes}, init counts
  // ----------------------------------------------------------------
  localparam logic [2:0] ENC_ACT  = 3'h3;
  localparam logic [2:0] ENC_RD   = 3'h5;
  localparam logic [2:0] ENC_WR   = 3'h4;
  localparam logic [2:0] ENC_PRE  = 3'h2;
  localparam logic [2:0] ENC_MRS  = 3'h0;
  localparam logic [2:0] ENC_REF  = 3'h1;
  localparam logic [2:0] ENC_STOP = 3'h6;
  localparam logic [3:0] REF_NEED = 4'h8;

  typedef enum logic [2:0] {
    SDCB_OP_NONE, SDCB_OP_ACT, SDCB_OP_RD, SDCB_OP_WR,
    SDCB_OP_PRE, SDCB_OP_MRS, SDCB_OP_REF, SDCB_OP_STOP
  } sdcb_op_t;

  typedef enum logic [1:0] {SDCB_INIT_PRE, SDCB_INIT_CFG, SDCB_INIT_READY} sdcb_init_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
  } sdcb_cmd_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
  } sdcb_maddr_t;
endpackage

// ---- rtl/sdcb_core.sv ----
// sdram command decoder, bank tracker and burst engine
`timescale 1ns/1ps

// Function
// - all strobes low loads mode from address
// - column strobe decode; write strobe picks direction
// - accept column commands every cycle
// - burst order and length from mode word
// - write data from command cycle, excess ignored
// - read restarts read, old data drains
// - write restarts write with full length
// - read ends write burst at once
// - burst stop ends page burst only
// - stopped read floats after cas latency
// - sequential wraps inside aligned block
// - interleave inverts low start bits per beat
// - mask floats reads two later, blocks writes
// - deselect ignores command, work continues
// - autoprecharge bit high precharges all banks
module sdcb_core (
  // clock, reset, clock gate
  input  wire logic                       core_clk_in,
  input  wire logic                       resetn_in,
  input  wire logic                       cke_in,
  // command pins and byte masks
  input  wire sdcb_pkg::sdcb_cmd_t        cmd_in,
  input  wire logic [sdcb_pkg::NBYTE-1:0]  dqm_in,
  // data pins, output enable low while driving
  input  wire logic [sdcb_pkg::DATA_W-1:0] dq_in,
  output logic      [sdcb_pkg::DATA_W-1:0] dq_out,
  output logic      [sdcb_pkg::NBYTE-1:0]  dq_oe_n_out,
  // array port
  output logic                            mem_wr_en_out,
  output sdcb_pkg::sdcb_maddr_t           mem_wr_addr_out,
  output logic      [sdcb_pkg::DATA_W-1:0] mem_wdata_out,
  output logic      [sdcb_pkg::NBYTE-1:0]  mem_wr_be_out,
  output logic                            mem_rd_en_out,
  output sdcb_pkg::sdcb_maddr_t           mem_rd_addr_out,
  input  wire logic [sdcb_pkg::DATA_W-1:0] mem_rdata_in,
  // status
  output logic                            init_done_out,
  output logic      [sdcb_pkg::NBANK-1:0]  bank_open_out,
  output logic                            cmd_error_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [sdcb_pkg::ADDR_W-1:0] mode_r;
  logic [sdcb_pkg::NBANK-1:0]  bank_open_r;
  logic [sdcb_pkg::ADDR_W-1:0] row_r [sdcb_pkg::NBANK];
  sdcb_pkg::sdcb_init_t        init_r;
  logic [3:0]                  ref_cnt_r;
  logic                        mode_seen_r;
  logic                        burst_act_r;
  logic                        wr_r;
  logic [sdcb_pkg::BANK_W-1:0] bank_r;
  logic [sdcb_pkg::COL_W-1:0]  start_r;
  logic [sdcb_pkg::COL_W-1:0]  beat_r;
  logic                        rd_v1_r;
  logic                        rd_v2_r;
  logic [sdcb_pkg::DATA_W-1:0] rd_d1_r;
  logic [sdcb_pkg::DATA_W-1:0] rd_d2_r;
  logic [sdcb_pkg::NBYTE-1:0]  dqm_d1_r;
  logic [sdcb_pkg::NBYTE-1:0]  dqm_d2_r;

  sdcb_pkg::sdcb_op_t          op;
  logic                        access_ok;
  logic                        page_mode;
  logic                        cl3;
  logic                        beat_valid;
  logic                        cur_wr;
  logic [sdcb_pkg::BANK_W-1:0] cur_bank;
  logic [sdcb_pkg::COL_W-1:0]  cur_start;
  logic [sdcb_pkg::COL_W-1:0]  cur_beat;
  logic [sdcb_pkg::COL_W-1:0]  blmask;
  logic [sdcb_pkg::COL_W-1:0]  cur_col;
  logic [sdcb_pkg::COL_W-1:0]  seq_sum;

  // ----------------------------------------------------------------
  // command decode; deselect yields no command at all
  // ----------------------------------------------------------------
  always_comb begin
    op = sdcb_pkg::SDCB_OP_NONE;
    if (!cmd_in.cs_n) begin
      case ({cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n})
        sdcb_pkg::ENC_ACT:  op = sdcb_pkg::SDCB_OP_ACT;
        sdcb_pkg::ENC_RD:   op = sdcb_pkg::SDCB_OP_RD;
        sdcb_pkg::ENC_WR:   op = sdcb_pkg::SDCB_OP_WR;
        sdcb_pkg::ENC_PRE:  op = sdcb_pkg::SDCB_OP_PRE;
        sdcb_pkg::ENC_MRS:  op = sdcb_pkg::SDCB_OP_MRS;
        sdcb_pkg::ENC_REF:  op = sdcb_pkg::SDCB_OP_REF;
        sdcb_pkg::ENC_STOP: op = sdcb_pkg::SDCB_OP_STOP;
        default:            op = sdcb_pkg::SDCB_OP_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // burst column generation
  // ----------------------------------------------------------------
  // burst length mask from the mode word
  always_comb begin
    case (mode_r[sdcb_pkg::MODE_BL_LSB +: 3])
      sdcb_pkg::BL_1:    blmask = sdcb_pkg::MASK_1;
      sdcb_pkg::BL_2:    blmask = sdcb_pkg::MASK_2;
      sdcb_pkg::BL_4:    blmask = sdcb_pkg::MASK_4;
      sdcb_pkg::BL_8:    blmask = sdcb_pkg::MASK_8;
      sdcb_pkg::BL_PAGE: blmask = sdcb_pkg::MASK_PG;
      default:           blmask = sdcb_pkg::MASK_1;
    endcase
  end

  assign page_mode = (mode_r[sdcb_pkg::MODE_BL_LSB +: 3] == sdcb_pkg::BL_PAGE);
  assign cl3       = (mode_r[sdcb_pkg::MODE_CL_LSB +: 3] == sdcb_pkg::CL_3);
  // an access to a closed bank is dropped rather than guessed at
  assign access_ok = ((op == sdcb_pkg::SDCB_OP_RD) || (op == sdcb_pkg::SDCB_OP_WR))
                     && bank_open_r[cmd_in.bank_select];
  assign cur_wr    = access_ok ? (op == sdcb_pkg::SDCB_OP_WR) : wr_r;
  assign cur_bank  = access_ok ? cmd_in.bank_select : bank_r;
  assign cur_start = access_ok ? cmd_in.addr[sdcb_pkg::COL_W-1:0] : start_r;
  assign cur_beat  = access_ok ? '0 : beat_r;
  // a page-mode stop does not consume a beat, a deselect does; stop halts only a page burst
  assign beat_valid = access_ok || (burst_act_r &&
                      !((op == sdcb_pkg::SDCB_OP_STOP) && page_mode));
  assign seq_sum   = cur_start + cur_beat;

  // interleave xors beat into the low bits; page bursts always count up
  always_comb begin
    if (mode_r[sdcb_pkg::MODE_BT_BIT] && !page_mode) begin
      cur_col = (cur_start & ~blmask) | ((cur_start ^ cur_beat) & blmask);
    end else begin
      cur_col = (cur_start & ~blmask) | (seq_sum & blmask);
    end
  end

  // ----------------------------------------------------------------
  // bank open flags and row latches, one per bank
  // ----------------------------------------------------------------
  for (genvar g = 0; g < sdcb_pkg::NBANK; g++) begin : g_bank
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        bank_open_r[g] <= 1'b0;
        row_r[g]       <= '0;
      end else if (cke_in) begin
        if ((op == sdcb_pkg::SDCB_OP_ACT) && (cmd_in.bank_select == g)) begin
          bank_open_r[g] <= 1'b1;
          row_r[g]       <= cmd_in.addr;
        end else if ((op == sdcb_pkg::SDCB_OP_PRE) && (cmd_in.addr[sdcb_pkg::AP_BIT] ||
                     (cmd_in.bank_select == g))) begin
          bank_open_r[g] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode word and init tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_r <= sdcb_pkg::MODE_RST;
    end else if (cke_in && (op == sdcb_pkg::SDCB_OP_MRS)) begin
      mode_r <= cmd_in.addr;
    end
  end

  // the device cannot see the power-up pause; it only watches the command order
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_r      <= sdcb_pkg::SDCB_INIT_PRE;
      ref_cnt_r   <= '0;
      mode_seen_r <= 1'b0;
    end else if (cke_in) begin
      case (init_r)
        sdcb_pkg::SDCB_INIT_PRE: begin
          if ((op == sdcb_pkg::SDCB_OP_PRE) && cmd_in.addr[sdcb_pkg::AP_BIT]) begin
            init_r <= sdcb_pkg::SDCB_INIT_CFG;
          end
        end
        sdcb_pkg::SDCB_INIT_CFG: begin
          if (op == sdcb_pkg::SDCB_OP_MRS) begin
            mode_seen_r <= 1'b1;
          end
          if ((op == sdcb_pkg::SDCB_OP_REF) && (ref_cnt_r != sdcb_pkg::REF_NEED)) begin
            ref_cnt_r <= ref_cnt_r + 4'h1;
          end
          if (mode_seen_r && (ref_cnt_r == sdcb_pkg::REF_NEED)) begin
            init_r <= sdcb_pkg::SDCB_INIT_READY;
          end
        end
        default: init_r <= sdcb_pkg::SDCB_INIT_READY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // burst engine: a new access always restarts at full length
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      burst_act_r <= 1'b0;
      wr_r        <= 1'b0;
      bank_r      <= '0;
      start_r     <= '0;
      beat_r      <= '0;
    end else if (cke_in) begin
      if (access_ok) begin
        burst_act_r <= (blmask != sdcb_pkg::MASK_1);
        wr_r        <= (op == sdcb_pkg::SDCB_OP_WR);
        bank_r      <= cmd_in.bank_select;
        start_r     <= cmd_in.addr[sdcb_pkg::COL_W-1:0];
        beat_r      <= 8'h01;
      end else if (burst_act_r && (op == sdcb_pkg::SDCB_OP_STOP) && page_mode) begin
        burst_act_r <= 1'b0;
      end else if (burst_act_r) begin
        beat_r <= beat_r + 8'h01;
        if (!page_mode && (beat_r == blmask)) begin
          burst_act_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // array write port; masked bytes never reach the array
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_wr_en_out   <= 1'b0;
      mem_wr_addr_out <= '0;
      mem_wdata_out   <= '0;
      mem_wr_be_out   <= '0;
    end else if (cke_in) begin
      mem_wr_en_out   <= beat_valid && cur_wr;
      mem_wr_addr_out <= '{bank: cur_bank, row: row_r[cur_bank], col: cur_col};
      mem_wdata_out   <= dq_in;
      mem_wr_be_out   <= ~dqm_in;
    end
  end

  // ----------------------------------------------------------------
  // read path: array answers in the same cycle as the address
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_rd_en_out   <= 1'b0;
      mem_rd_addr_out <= '0;
      rd_v1_r         <= 1'b0;
      rd_v2_r         <= 1'b0;
      rd_d1_r         <= '0;
      rd_d2_r         <= '0;
    end else if (cke_in) begin
      mem_rd_en_out   <= beat_valid && !cur_wr;
      mem_rd_addr_out <= '{bank: cur_bank, row: row_r[cur_bank], col: cur_col};
      rd_v1_r         <= mem_rd_en_out;
      rd_d1_r         <= mem_rdata_in;
      rd_v2_r         <= rd_v1_r;
      rd_d2_r         <= rd_d1_r;
    end
  end

  // queued data keeps draining after an interrupting read, as the pins demand
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dqm_d1_r    <= '0;
      dqm_d2_r    <= '0;
      dq_out      <= '0;
      dq_oe_n_out <= '1;
    end else if (cke_in) begin
      dqm_d1_r <= dqm_in;
      dqm_d2_r <= dqm_d1_r;
      dq_out   <= cl3 ? rd_d2_r : rd_d1_r;
      for (int b = 0; b < sdcb_pkg::NBYTE; b++) begin
        dq_oe_n_out[b] <= !((cl3 ? rd_v2_r : rd_v1_r) && !dqm_d2_r[b]);
      end
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_done_out <= 1'b0;
      bank_open_out <= '0;
      cmd_error_out <= 1'b0;
    end else if (cke_in) begin
      init_done_out <= (init_r == sdcb_pkg::SDCB_INIT_READY);
      bank_open_out <= bank_open_r;
      cmd_error_out <= (((op == sdcb_pkg::SDCB_OP_RD) || (op == sdcb_pkg::SDCB_OP_WR)) &&
                        !access_ok) || ((op == sdcb_pkg::SDCB_OP_STOP) && !page_mode);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_mrs;
    cke_in && (op == sdcb_pkg::SDCB_OP_MRS);
  endsequence
  sequence s_bl4_seq_wr;
    cke_in && access_ok && (op == sdcb_pkg::SDCB_OP_WR) &&
    (mode_r[sdcb_pkg::MODE_BL_LSB +: 3] == sdcb_pkg::BL_4) && !mode_r[sdcb_pkg::MODE_BT_BIT];
  endsequence
  sequence s_quiet;
    cke_in && (op == sdcb_pkg::SDCB_OP_NONE);
  endsequence

  mode_load_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_mrs |=> (mode_r == $past(cmd_in.addr)))
    else $error("mode word not loaded");

  prech_all_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cke_in && (op == sdcb_pkg::SDCB_OP_PRE) && cmd_in.addr[sdcb_pkg::AP_BIT])
    |=> (bank_open_r == '0))
    else $error("precharge all left a bank open");

  activate_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cke_in && (op == sdcb_pkg::SDCB_OP_ACT)) |=> ##1 bank_open_out[$past(cmd_in.bank_select, 2)])
    else $error("activated bank not shown open");

  deselect_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cke_in && cmd_in.cs_n) |=> ($stable(mode_r) && $stable(bank_open_r)))
    else $error("deselect changed state");

  wr_mask_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cke_in && access_ok && (op == sdcb_pkg::SDCB_OP_WR))
    |=> (mem_wr_en_out && (mem_wr_be_out == ~$past(dqm_in))))
    else $error("write byte mask wrong");

  bl4_seq_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_bl4_seq_wr ##1 s_quiet[*3] |-> (mem_wr_addr_out.col[1:0] ==
      $past(mem_wr_addr_out.col[1:0]) + 2'h1))
    else $error("sequential column step wrong");

  bl4_end_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_bl4_seq_wr ##1 s_quiet[*4] |-> !burst_act_r)
    else $error("four beat burst overran");

  page_stop_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cke_in && burst_act_r && page_mode && (op == sdcb_pkg::SDCB_OP_STOP))
    |=> (!burst_act_r && bank_open_r == $past(bank_open_r)))
    else $error("burst stop did not end page burst");

  read_cl2_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (cke_in && access_ok && (op == sdcb_pkg::SDCB_OP_RD) && !cl3 && (dqm_in == '0))
    ##1 cke_in[*3] |-> (dq_oe_n_out == '0))
    else $error("read data missing at latency two");

endmodule

// ---- tb/sdcb_ctrl_model.sv ----
// controller stand-in driving command, mask and write data pins
`timescale 1ns/1ps
module sdcb_ctrl_model #(
  parameter int PAUSE_CYC = 40  // power-up pause, shortened to keep the run brief
) (
  // bench clock
  input  wire logic           clk_in,
  // pins toward the device
  output sdcb_pkg::sdcb_cmd_t cmd_out,
  output logic                cke_out,
  output logic [3:0]          dqm_out,
  output logic [31:0]         dq_out
);
  // masks and gate high from time zero so the pause sees no contention
  initial begin
    cmd_out = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 11'h000};
    cke_out = 1'b1;
    dqm_out = 4'hF;
    dq_out  = 32'h0000_0000;
  end
  // one command per falling edge, held until the next one
  task automatic issue(input logic cs_n, input logic [2:0] enc, input logic [1:0] bank,
                       input logic [10:0] addr, input logic [3:0] dqm, input logic [31:0] dq);
    @(negedge clk_in);
    cke_out = 1'b1;
    cmd_out = '{cs_n, enc[2], enc[1], enc[0], bank, addr};
    dqm_out = dqm;
    dq_out  = dq;
  endtask
  // released data lines toggle so a stale word never passes for data
  task automatic idle(input int n);
    repeat (n) issue(1'b0, 3'h7, 2'h0, 11'h000, 4'h0, ~dq_out);
  endtask
  // gate low with a read on the pins; a frozen device must not take it
  task automatic freeze(input int n);
    repeat (n) begin
      @(negedge clk_in);
      cke_out = 1'b0;
      cmd_out = '{1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 11'h000};
      dqm_out = 4'h0;
    end
  endtask
  // close all banks, load the mode word, sit out the recovery
  task automatic set_mode(input logic [10:0] mode);
    issue(1'b0, sdcb_pkg::ENC_PRE, 2'h0, 11'h400, 4'h0, ~dq_out);
    issue(1'b0, sdcb_pkg::ENC_MRS, 2'h0, mode, 4'h0, ~dq_out);
    idle(2);
  endtask
  // pause, precharge all, mode set, eight refreshes
  task automatic power_up(input logic [10:0] mode);
    repeat (PAUSE_CYC) @(negedge clk_in);
    set_mode(mode);
    repeat (8) issue(1'b0, sdcb_pkg::ENC_REF, 2'h0, 11'h000, 4'h0, ~dq_out);
    idle(2);
  endtask
  // activate, then wait the access delay before any column command
  task automatic open_row(input logic [1:0] bank);
    issue(1'b0, sdcb_pkg::ENC_ACT, bank, 11'h055, 4'h0, ~dq_out);
    idle(3);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the sdram command and burst core
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // clock, reset, wiring
  // ----------------------------------------------------------------
  logic                  core_clk_in = 1'b0;
  logic                  resetn_in   = 1'b0;
  sdcb_pkg::sdcb_cmd_t   cmd;
  logic                  cke;
  logic [3:0]            dqm;
  logic [31:0]           dq_w;
  logic [31:0]           dq_rd;
  logic [3:0]            oe_n;
  logic                  wr_en;
  sdcb_pkg::sdcb_maddr_t wr_addr;
  logic [31:0]           wdata;
  logic [3:0]            wbe;
  logic                  rd_en;
  sdcb_pkg::sdcb_maddr_t rd_addr;
  logic [31:0]           rdata;
  logic                  init_done;
  logic [3:0]            bank_open;
  logic                  cmd_err;
  int                    fail_count  = 0;
  int                    comparisons = 0;
  int                    cycles      = 0;
  logic                  cke_q       = 1'b1;
  logic [7:0]            ec[$];
  logic [7:0]            wq[$];
  logic [7:0]            rq[$];
  logic [31:0]           wdq[$];
  logic [31:0]           dqq[$];
  logic [3:0]            wbq[$];

  always #2.5 core_clk_in = ~core_clk_in;
  // array stand-in: the word spells out its own address
  assign rdata = {11'h2AA, rd_addr};

  sdcb_ctrl_model ctrl_i (.clk_in(core_clk_in), .cmd_out(cmd), .cke_out(cke),
                          .dqm_out(dqm), .dq_out(dq_w));
  sdcb_core sdcb_core_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .cke_in(cke),
    .cmd_in(cmd), .dqm_in(dqm), .dq_in(dq_w), .dq_out(dq_rd), .dq_oe_n_out(oe_n),
    .mem_wr_en_out(wr_en), .mem_wr_addr_out(wr_addr), .mem_wdata_out(wdata),
    .mem_wr_be_out(wbe), .mem_rd_en_out(rd_en), .mem_rd_addr_out(rd_addr),
    .mem_rdata_in(rdata), .init_done_out(init_done), .bank_open_out(bank_open),
    .cmd_error_out(cmd_err));

  // ----------------------------------------------------------------
  // monitor, timeout, checks
  // ----------------------------------------------------------------
  // every beat is logged; the bench compares whole bursts afterwards
  always @(posedge core_clk_in) begin
    cycles++;
    // outputs held by a low gate would otherwise be logged twice
    if (cke_q && wr_en === 1'b1) begin
      wq.push_back(wr_addr.col);
      wdq.push_back(wdata);
      wbq.push_back(wbe);
    end
    if (cke_q && rd_en === 1'b1) rq.push_back(rd_addr.col);
    if (cke_q && oe_n !== 4'hF) dqq.push_back(dq_rd);
    cke_q = cke;
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_cnt(input string nm, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      fail_count++;
      $display("FAIL %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // compare a logged column list with the expected one
  task automatic chk_cols(input string nm, ref logic [7:0] q[$]);
    chk_cnt(nm, ec.size(), q.size());
    foreach (ec[k]) chk(nm, 32'(ec[k]), 32'(q[k]));
  endtask
  // read words carry their address; skip drops beats floated by the mask
  task automatic chk_rd(input int skip);
    chk_cols("rd_col", rq);
    chk_cnt("rd_words", ec.size() - skip, dqq.size());
    foreach (dqq[k]) chk("rd_data", {11'h2AA, 2'h1, 11'h055, ec[k+skip]}, dqq[k]);
  endtask
  // expected columns: wrap inside the mask, interleave by xor of the beat
  task automatic exp_add(input logic [7:0] s, input logic [7:0] m, input bit il, input int n);
    for (int k = 0; k < n; k++)
      ec.push_back(il ? ((s & ~m) | ((s ^ 8'(k)) & m)) : ((s & ~m) | ((s + 8'(k)) & m)));
  endtask
  task automatic clr();
    ec.delete();
    wq.delete();
    rq.delete();
    wdq.delete();
    dqq.delete();
    wbq.delete();
  endtask
  task automatic wr(input logic [7:0] c, input int n, input logic [31:0] d, input logic [3:0] m);
    ctrl_i.issue(1'b0, sdcb_pkg::ENC_WR, 2'h1, {3'h0, c}, 4'h0, d);
    for (int k = 1; k < n; k++) ctrl_i.issue(1'b0, 3'h7, 2'h1, 11'h000, (k == 1) ? m : 4'h0, d + k);
  endtask
  task automatic cmd1(input logic [2:0] enc, input logic [7:0] c, input logic [3:0] m);
    ctrl_i.issue(1'b0, enc, 2'h1, {3'h0, c}, m, ~dq_w);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge core_clk_in);
    chk("oe_rst", 32'h0000_000F, 32'(oe_n));
    resetn_in = 1'b1;
    ctrl_i.power_up(11'h022);
    ctrl_i.idle(1);
    chk("init_done", 32'h1, 32'(init_done));
    // open shows one edge after the edge that takes the activate
    ctrl_i.issue(1'b0, sdcb_pkg::ENC_ACT, 2'h1, 11'h055, 4'h0, ~dq_w);
    ctrl_i.idle(1);
    chk("bank_open", 32'h0, 32'(bank_open));
    ctrl_i.idle(1);
    chk("bank_open", 32'h2, 32'(bank_open));
    // write past the burst end, one masked beat
    clr();
    wr(8'h02, 6, 32'h0000_1000, 4'h3);
    ctrl_i.idle(4);
    exp_add(8'h02, sdcb_pkg::MASK_4, 1'b0, 4);
    chk_cols("wr_col", wq);
    foreach (ec[k]) chk("wr_data", 32'h0000_1000 + k, wdq[k]);
    chk("wr_be", 32'h0000_000C, 32'(wbq[1]));
    // fully masked first beat, interrupted by a second read
    clr();
    cmd1(sdcb_pkg::ENC_RD, 8'h05, 4'hF);
    cmd1(sdcb_pkg::ENC_RD, 8'h26, 4'h0);
    ctrl_i.idle(8);
    ec.push_back(8'h05);
    exp_add(8'h26, sdcb_pkg::MASK_4, 1'b0, 4);
    chk_rd(1);
    // write into write into write, then a read cuts the last
    clr();
    wr(8'h08, 2, 32'h0000_2000, 4'h0);
    wr(8'h30, 4, 32'h0000_3000, 4'h0);
    wr(8'h40, 2, 32'h0000_4000, 4'h0);
    cmd1(sdcb_pkg::ENC_RD, 8'h50, 4'h0);
    ctrl_i.idle(8);
    exp_add(8'h08, sdcb_pkg::MASK_4, 1'b0, 2);
    exp_add(8'h30, sdcb_pkg::MASK_4, 1'b0, 4);
    exp_add(8'h40, sdcb_pkg::MASK_4, 1'b0, 2);
    chk_cols("wr_col", wq);
    ec.delete();
    exp_add(8'h50, sdcb_pkg::MASK_4, 1'b0, 4);
    chk_rd(0);
    // closed bank, stop outside page mode, deselected command
    clr();
    ctrl_i.issue(1'b0, sdcb_pkg::ENC_RD, 2'h2, 11'h000, 4'h0, ~dq_w);
    ctrl_i.idle(1);
    chk("err", 32'h1, 32'(cmd_err));
    wr(8'h60, 1, 32'h0000_6000, 4'h0);
    cmd1(sdcb_pkg::ENC_STOP, 8'h00, 4'h0);
    chk("err", 32'h0, 32'(cmd_err));
    ctrl_i.idle(1);
    chk("err", 32'h1, 32'(cmd_err));
    wr(8'h70, 1, 32'h0000_7000, 4'h0);
    ctrl_i.issue(1'b1, sdcb_pkg::ENC_RD, 2'h1, 11'h010, 4'h0, ~dq_w);
    ctrl_i.idle(6);
    exp_add(8'h60, sdcb_pkg::MASK_4, 1'b0, 3);
    exp_add(8'h70, sdcb_pkg::MASK_4, 1'b0, 4);
    chk_cols("wr_col", wq);
    chk_cnt("rd_beats", 0, rq.size());
    // interleaved eight-beat write after a reload
    clr();
    ctrl_i.set_mode(11'h02B);
    chk("bank_open", 32'h0, 32'(bank_open));
    ctrl_i.open_row(2'h1);
    wr(8'h05, 8, 32'h0000_8000, 4'h0);
    ctrl_i.idle(4);
    exp_add(8'h05, sdcb_pkg::MASK_8, 1'b1, 8);
    chk_cols("wr_col", wq);
    // full page: wrap across the row end, then stops
    clr();
    ctrl_i.set_mode(11'h027);
    ctrl_i.open_row(2'h1);
    wr(8'hFE, 3, 32'h0000_9000, 4'h0);
    cmd1(sdcb_pkg::ENC_STOP, 8'h00, 4'h0);
    ctrl_i.idle(4);
    exp_add(8'hFE, sdcb_pkg::MASK_PG, 1'b0, 3);
    chk_cols("wr_col", wq);
    clr();
    cmd1(sdcb_pkg::ENC_RD, 8'h10, 4'h0);
    ctrl_i.idle(1);
    cmd1(sdcb_pkg::ENC_STOP, 8'h00, 4'h0);
    ctrl_i.idle(8);
    exp_add(8'h10, sdcb_pkg::MASK_PG, 1'b0, 2);
    chk_rd(0);
    // masked read cut by a write, then a gated clock inside the page burst
    clr();
    cmd1(sdcb_pkg::ENC_RD, 8'h40, 4'hF);
    wr(8'h48, 2, 32'h0000_A000, 4'hF);
    ctrl_i.freeze(2);
    ctrl_i.idle(1);
    cmd1(sdcb_pkg::ENC_STOP, 8'h00, 4'h0);
    ctrl_i.idle(4);
    exp_add(8'h48, sdcb_pkg::MASK_PG, 1'b0, 3);
    chk_cols("wr_col", wq);
    chk("wr_be", 32'h0, 32'(wbq[1]));
    chk_cnt("rd_beats", 1, rq.size());
    chk_cnt("rd_words", 0, dqq.size());
    // single-bank precharge leaves the other bank open
    ctrl_i.open_row(2'h2);
    chk("bank_open", 32'h6, 32'(bank_open));
    ctrl_i.issue(1'b0, sdcb_pkg::ENC_PRE, 2'h2, 11'h000, 4'h0, ~dq_w);
    ctrl_i.idle(3);
    chk("bank_open", 32'h2, 32'(bank_open));
    end_sim();
  end
endmodule
